// file: hw/clamp_gain_offset_pkg.sv
`default_nettype none
package clamp_gain_offset_pkg;

  // register map, byte addresses on the serial control port
  localparam int REG_ADDR_W = 8;
  localparam int REG_INDEX_W = 5;
  localparam int REG_FILE_DEPTH = 32;
  localparam int REG_PAIR_STRIDE = 2;
  localparam logic [7:0] RED_GAIN_UPPER_ADDR = 8'h05;
  localparam logic [7:0] RED_GAIN_LOWER_ADDR = 8'h06;
  localparam logic [7:0] GREEN_GAIN_UPPER_ADDR = 8'h07;
  localparam logic [7:0] GREEN_GAIN_LOWER_ADDR = 8'h08;
  localparam logic [7:0] BLUE_GAIN_UPPER_ADDR = 8'h09;
  localparam logic [7:0] BLUE_GAIN_LOWER_ADDR = 8'h0a;
  localparam logic [7:0] RED_OFFSET_UPPER_ADDR = 8'h0b;
  localparam logic [7:0] RED_OFFSET_LOWER_ADDR = 8'h0c;
  localparam logic [7:0] GREEN_OFFSET_UPPER_ADDR = 8'h0d;
  localparam logic [7:0] GREEN_OFFSET_LOWER_ADDR = 8'h0e;
  localparam logic [7:0] BLUE_OFFSET_UPPER_ADDR = 8'h0f;
  localparam logic [7:0] BLUE_OFFSET_LOWER_ADDR = 8'h10;
  localparam logic [7:0] CLAMP_CONFIGURATION_ADDR = 8'h18;
  localparam logic [7:0] CLAMP_START_DELAY_ADDR = 8'h19;
  localparam logic [7:0] CLAMP_LENGTH_ADDR = 8'h1a;
  localparam logic [7:0] OFFSET_MODE_CONTROL_ADDR = 8'h1b;

  // field positions
  localparam int CLAMP_POL_LSB = 6;
  localparam int CLAMP_SOURCE_BIT = 4;
  localparam int CLAMP_MID_RED_BIT = 3;
  localparam int AUTO_OFFSET_EN_BIT = 5;
  localparam int GAIN_LOWER_BIT = 7;
  localparam int OFFSET_UPPER_MSB = 6;
  localparam int OFFSET_LOWER_LSB = 6;

  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] START_DELAY_RESET = 8'h04;
  localparam logic [7:0] LENGTH_RESET = 8'h28;

  // data path
  localparam int NUM_CH = 3;
  localparam int CODE_W = 10;
  localparam int GAIN_W = 9;
  localparam int OFFSET_W = 9;
  localparam int CORR_W = 11;
  localparam int SUM_W = 13;
  localparam int COUNT_W = 8;
  localparam logic [CODE_W-1:0] GROUND_CODE = 10'h000;
  localparam logic [CODE_W-1:0] MIDSCALE_CODE = 10'h200;
  localparam logic [CODE_W-1:0] CODE_MAX = 10'h3ff;
  localparam logic [GAIN_W-1:0] GAIN_MAX = 9'h1ff;
  localparam logic signed [OFFSET_W-1:0] OFFSET_MOST_NEG = 9'sh100;
  localparam logic signed [OFFSET_W-1:0] OFFSET_NEG_LIMIT = 9'sh101;
  localparam logic signed [CORR_W-1:0] CORR_POS_LIMIT = 11'sh3ff;
  localparam logic signed [CORR_W-1:0] CORR_NEG_LIMIT = 11'sh401;

  // serial control port
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_ADDR_ACK = 3'b011,
    I2C_WDATA = 3'b010,
    I2C_WACK = 3'b110,
    I2C_RDATA = 3'b111,
    I2C_RACK = 3'b101
  } i2c_state_t;

  typedef enum logic [1:0] {
    CLAMP_IDLE = 2'b00,
    CLAMP_WAIT = 2'b01,
    CLAMP_HOLD = 2'b11
  } clamp_state_t;

endpackage : clamp_gain_offset_pkg
`default_nettype wire

// file: hw/pin_synchronizer.sv
`timescale 1ns/1ps
`default_nettype none
module pin_synchronizer #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  if (WIDTH < 1) begin : g_check
    $error("pin_synchronizer: WIDTH must be at least 1");
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule : pin_synchronizer
`default_nettype wire

// file: hw/clamp_pulse_generator.sv
`timescale 1ns/1ps
`default_nettype none
module clamp_pulse_generator #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsync_level,
  input wire logic [WIDTH-1:0] start_delay,
  input wire logic [WIDTH-1:0] length,
  output logic clamp
);
  import clamp_gain_offset_pkg::*;

  clamp_state_t state_reg, state_next;
  logic [WIDTH-1:0] count_reg, count_next;
  logic hsync_prev_reg;
  logic clamp_reg, clamp_next;
  logic trailing;

  if (WIDTH < 1) begin : g_check
    $error("clamp_pulse_generator: WIDTH must be at least 1");
  end

  // sync is active high, so its trailing edge is a fall
  assign trailing = hsync_prev_reg & ~hsync_level;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    if (trailing) begin
      if (start_delay != '0) begin
        state_next = CLAMP_WAIT; // RL3
        count_next = start_delay;
      end else if (length != '0) begin
        state_next = CLAMP_HOLD;
        count_next = length;
      end else begin
        state_next = CLAMP_IDLE;
      end
    end else begin
      unique case (state_reg)
        CLAMP_IDLE: begin
          state_next = CLAMP_IDLE;
        end
        CLAMP_WAIT: begin
          count_next = count_reg - 1'b1;
          if (count_reg == WIDTH'(1)) begin
            state_next = (length != '0) ? CLAMP_HOLD : CLAMP_IDLE;
            count_next = length;
          end
        end
        CLAMP_HOLD: begin
          count_next = count_reg - 1'b1; // RL4
          if (count_reg == WIDTH'(1)) begin
            state_next = CLAMP_IDLE;
          end
        end
        default: begin
          state_next = CLAMP_IDLE;
        end
      endcase
    end
    clamp_next = (state_next == CLAMP_HOLD);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= CLAMP_IDLE;
      count_reg <= '0;
      hsync_prev_reg <= 1'b0;
      clamp_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      hsync_prev_reg <= hsync_level;
      clamp_reg <= clamp_next;
    end
  end

  assign clamp = clamp_reg;
endmodule : clamp_pulse_generator
`default_nettype wire

// file: hw/clamp_gain_offset_control.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RL1: clamp source bit set selects the external clamp pin over the generator.
// RL2: two-bit polarity field decides the active level of the external clamp pin; the code reads only the low bit of the field, bit 6.
// RL3: generator waits the programmed pixel periods after sync trailing edge.
// RL4: generator holds clamp for programmed length; delay and length are 8-bit.
// RL5: host should program delay four and length forty pixel periods.
// RL6: ground clamp drives the channel to output code zero on black.
// RL7: each channel has its own midscale-or-ground clamp target bit.
// RL8: midscale target is code 512, ground target is code 0.
// RL9: 9-bit gain per channel over a register pair, red, green, blue.
// RL10: gain code zero is highest gain, 511 is lowest gain.
// RL11: 9-bit offset per channel over a register pair, red, green, blue.
// RL12: offset registers mean manual offset only while auto offset is off.
// RL13: manual offset is upper bits six to zero plus lower bits seven, six.
// RL14: manual offset spans plus or minus 255, one code per step.
// RL15: with clamp source zero, clamp comes from the pixel-clocked counters.
module clamp_gain_offset_control #(
  parameter logic [6:0] DEVICE_ADDRESS = 7'h4c // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic horizontal_sync_input_a,
  input wire logic horizontal_sync_input_b,
  input wire logic hsync_input_select,
  input wire logic clamp_pin,
  input wire logic [clamp_gain_offset_pkg::CODE_W-1:0] adc_code_red,
  input wire logic [clamp_gain_offset_pkg::CODE_W-1:0] adc_code_green,
  input wire logic [clamp_gain_offset_pkg::CODE_W-1:0] adc_code_blue,
  output logic [clamp_gain_offset_pkg::CODE_W-1:0] corrected_code_red,
  output logic [clamp_gain_offset_pkg::CODE_W-1:0] corrected_code_green,
  output logic [clamp_gain_offset_pkg::CODE_W-1:0] corrected_code_blue,
  output logic [clamp_gain_offset_pkg::GAIN_W-1:0] programmable_gain_amplifier_red,
  output logic [clamp_gain_offset_pkg::GAIN_W-1:0] programmable_gain_amplifier_green,
  output logic [clamp_gain_offset_pkg::GAIN_W-1:0] programmable_gain_amplifier_blue,
  output logic clamp_active,
  output logic clamp_midscale_red,
  output logic clamp_midscale_green,
  output logic clamp_midscale_blue
);
  import clamp_gain_offset_pkg::*;

  if (DEVICE_ADDRESS == 7'h00) begin : g_check
    $error("clamp_gain_offset_control: address zero is the general call");
  end

  // ---- pin synchronisation ----
  logic [5:0] pins_async;
  logic [5:0] pins_sync;
  logic scl_s, sda_s, hsync_a_s, hsync_b_s, hsync_sel_s, clamp_pin_s;

  assign pins_async = {scl, sda_in, horizontal_sync_input_a, horizontal_sync_input_b,
                       hsync_input_select, clamp_pin};
  assign {scl_s, sda_s, hsync_a_s, hsync_b_s, hsync_sel_s, clamp_pin_s} = pins_sync;

  pin_synchronizer #(.WIDTH(6)) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );

  // ---- serial control port ----
  i2c_state_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [REG_ADDR_W-1:0] ptr_reg, ptr_next;
  logic rw_reg, rw_next;
  logic sub_reg, sub_next;
  logic nack_reg, nack_next;
  logic oe_reg, oe_next;
  logic sda_out_reg;
  logic scl_d_reg, sda_d_reg;
  logic start_cond, stop_cond, scl_rise, scl_fall;
  logic wr_en;
  logic load_rd;
  logic [7:0] rd_data;

  logic [7:0] regs_reg [REG_FILE_DEPTH];
  logic [7:0] regs_next [REG_FILE_DEPTH];

  function automatic logic is_mapped(input logic [REG_ADDR_W-1:0] a);
    is_mapped = ((a >= RED_GAIN_UPPER_ADDR) && (a <= BLUE_OFFSET_LOWER_ADDR)) ||
                ((a >= CLAMP_CONFIGURATION_ADDR) && (a <= OFFSET_MODE_CONTROL_ADDR));
  endfunction : is_mapped

  assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  // unmapped addresses read as zero
  assign rd_data = is_mapped(ptr_reg) ? regs_reg[ptr_reg[REG_INDEX_W-1:0]] : 8'h00;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    sub_next = sub_reg;
    nack_next = nack_reg;
    oe_next = oe_reg;
    wr_en = 1'b0;
    load_rd = 1'b0;
    if (start_cond) begin
      st_next = I2C_ADDR;
      cnt_next = '0;
      oe_next = 1'b0;
    end else if (stop_cond) begin
      st_next = I2C_IDLE;
      oe_next = 1'b0;
    end else begin
      unique case (st_reg)
        I2C_IDLE: begin
          oe_next = 1'b0;
        end
        I2C_ADDR, I2C_WDATA: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && (cnt_reg == BITS_PER_BYTE)) begin
            cnt_next = '0;
            if (st_reg == I2C_ADDR) begin
              if (shift_reg[7:1] == DEVICE_ADDRESS) begin
                oe_next = 1'b1;
                rw_next = shift_reg[0];
                st_next = I2C_ADDR_ACK;
              end else begin
                st_next = I2C_IDLE;
              end
            end else begin
              oe_next = 1'b1;
              st_next = I2C_WACK;
              if (sub_reg) begin
                ptr_next = shift_reg;
                sub_next = 1'b0;
              end else begin
                wr_en = 1'b1;
                ptr_next = ptr_reg + 8'h01;
              end
            end
          end
        end
        I2C_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              load_rd = 1'b1;
            end else begin
              oe_next = 1'b0;
              sub_next = 1'b1;
              st_next = I2C_WDATA;
            end
          end
        end
        I2C_WACK: begin
          if (scl_fall) begin
            oe_next = 1'b0;
            st_next = I2C_WDATA;
          end
        end
        I2C_RDATA: begin
          if (scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (cnt_reg == BITS_PER_BYTE) begin
              oe_next = 1'b0;
              st_next = I2C_RACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next = ~shift_reg[6];
            end
          end
        end
        I2C_RACK: begin
          if (scl_rise) begin
            nack_next = sda_s;
          end else if (scl_fall) begin
            if (nack_reg) begin
              st_next = I2C_IDLE;
            end else begin
              load_rd = 1'b1;
            end
          end
        end
        default: begin
          st_next = I2C_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
    if (load_rd) begin
      shift_next = rd_data;
      oe_next = ~rd_data[7];
      ptr_next = ptr_reg + 8'h01;
      cnt_next = '0;
      st_next = I2C_RDATA;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= I2C_IDLE;
      cnt_reg <= '0;
      shift_reg <= '0;
      ptr_reg <= '0;
      rw_reg <= 1'b0;
      sub_reg <= 1'b0;
      nack_reg <= 1'b1;
      oe_reg <= 1'b0;
      sda_out_reg <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      sub_reg <= sub_next;
      nack_reg <= nack_next;
      oe_reg <= oe_next;
      sda_out_reg <= 1'b0;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign sda_out = sda_out_reg;
  assign sda_oe = oe_reg;

  // ---- register file ----
  always_comb begin
    regs_next = regs_reg;
    if (wr_en && is_mapped(ptr_reg)) begin
      regs_next[ptr_reg[REG_INDEX_W-1:0]] = shift_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < REG_FILE_DEPTH; i++) begin
        regs_reg[i] <= REG_RESET;
      end
      regs_reg[CLAMP_START_DELAY_ADDR[REG_INDEX_W-1:0]] <= START_DELAY_RESET; // RL5
      regs_reg[CLAMP_LENGTH_ADDR[REG_INDEX_W-1:0]] <= LENGTH_RESET; // RL5
    end else begin
      regs_reg <= regs_next;
    end
  end

  logic [7:0] clamp_cfg;
  logic auto_offset_en;
  assign clamp_cfg = regs_reg[CLAMP_CONFIGURATION_ADDR[REG_INDEX_W-1:0]];
  assign auto_offset_en = regs_reg[OFFSET_MODE_CONTROL_ADDR[REG_INDEX_W-1:0]][AUTO_OFFSET_EN_BIT];

  // ---- clamp timing ----
  logic hsync_level;
  logic gen_clamp;
  logic ext_clamp;
  logic clamp_reg, clamp_next;

  assign hsync_level = hsync_sel_s ? hsync_b_s : hsync_a_s;

  clamp_pulse_generator #(.WIDTH(COUNT_W)) u_clamp_gen (
    .clk(clk),
    .rst(rst),
    .hsync_level(hsync_level),
    .start_delay(regs_reg[CLAMP_START_DELAY_ADDR[REG_INDEX_W-1:0]]),
    .length(regs_reg[CLAMP_LENGTH_ADDR[REG_INDEX_W-1:0]]),
    .clamp(gen_clamp)
  );

  // low polarity bit set means the pin is active low
  assign ext_clamp = clamp_pin_s ^ clamp_cfg[CLAMP_POL_LSB]; // RL2

  always_comb begin
    clamp_next = clamp_cfg[CLAMP_SOURCE_BIT] ? ext_clamp : gen_clamp; // RL1 RL15
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clamp_reg <= 1'b0;
    end else begin
      clamp_reg <= clamp_next;
    end
  end

  assign clamp_active = clamp_reg;

  // ---- per-channel gain, offset and restore ----
  logic [CODE_W-1:0] raw [NUM_CH];
  logic [CODE_W-1:0] code_reg [NUM_CH];
  logic [GAIN_W-1:0] level_reg [NUM_CH];
  logic mid_reg [NUM_CH];

  assign raw[0] = adc_code_red;
  assign raw[1] = adc_code_green;
  assign raw[2] = adc_code_blue;

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    localparam logic [REG_INDEX_W-1:0] GU =
      REG_INDEX_W'(int'(RED_GAIN_UPPER_ADDR) + REG_PAIR_STRIDE * ch);
    localparam logic [REG_INDEX_W-1:0] GL =
      REG_INDEX_W'(int'(RED_GAIN_LOWER_ADDR) + REG_PAIR_STRIDE * ch);
    localparam logic [REG_INDEX_W-1:0] OU =
      REG_INDEX_W'(int'(RED_OFFSET_UPPER_ADDR) + REG_PAIR_STRIDE * ch);
    localparam logic [REG_INDEX_W-1:0] OL =
      REG_INDEX_W'(int'(RED_OFFSET_LOWER_ADDR) + REG_PAIR_STRIDE * ch);

    logic [GAIN_W-1:0] gain_code;
    logic signed [OFFSET_W-1:0] man_offset;
    logic mid_sel;
    logic [CODE_W-1:0] target;
    logic signed [CORR_W-1:0] corr_reg, corr_next;
    logic [CODE_W-1:0] code_next;
    logic [GAIN_W-1:0] level_next;
    logic signed [SUM_W-1:0] meas;
    logic signed [SUM_W-1:0] outv;
    logic signed [OFFSET_W-1:0] off_eff;

    assign gain_code = {regs_reg[GU], regs_reg[GL][GAIN_LOWER_BIT]}; // RL9
    assign man_offset = {regs_reg[OU][OFFSET_UPPER_MSB:0],
                         regs_reg[OL][7:OFFSET_LOWER_LSB]}; // RL11 RL13
    assign mid_sel = clamp_cfg[CLAMP_MID_RED_BIT - ch]; // RL7
    assign target = mid_sel ? MIDSCALE_CODE : GROUND_CODE; // RL8

    always_comb begin
      meas = $signed({3'b000, raw[ch]}) + SUM_W'(corr_reg);
      corr_next = corr_reg;
      if (clamp_reg) begin
        if ((meas > $signed({3'b000, target})) && (corr_reg != CORR_NEG_LIMIT)) begin
          corr_next = corr_reg - 11'sd1; // RL6
        end else if ((meas < $signed({3'b000, target})) && (corr_reg != CORR_POS_LIMIT)) begin
          corr_next = corr_reg + 11'sd1; // RL6
        end
      end
      // auto offset disables the manual term
      if (auto_offset_en) begin
        off_eff = '0; // RL12
      end else if (man_offset == OFFSET_MOST_NEG) begin
        off_eff = OFFSET_NEG_LIMIT; // RL14
      end else begin
        off_eff = man_offset;
      end
      outv = meas + SUM_W'(off_eff); // RL14
      if (outv < 0) begin
        code_next = GROUND_CODE;
      end else if (outv > $signed({3'b000, CODE_MAX})) begin
        code_next = CODE_MAX;
      end else begin
        code_next = outv[CODE_W-1:0];
      end
      level_next = GAIN_MAX - gain_code; // RL10
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        corr_reg <= '0;
        code_reg[ch] <= GROUND_CODE;
        level_reg[ch] <= '0;
        mid_reg[ch] <= 1'b0;
      end else begin
        corr_reg <= corr_next;
        code_reg[ch] <= code_next;
        level_reg[ch] <= level_next;
        mid_reg[ch] <= mid_sel;
      end
    end
  end

  assign corrected_code_red = code_reg[0];
  assign corrected_code_green = code_reg[1];
  assign corrected_code_blue = code_reg[2];
  assign programmable_gain_amplifier_red = level_reg[0];
  assign programmable_gain_amplifier_green = level_reg[1];
  assign programmable_gain_amplifier_blue = level_reg[2];
  assign clamp_midscale_red = mid_reg[0];
  assign clamp_midscale_green = mid_reg[1];
  assign clamp_midscale_blue = mid_reg[2];

endmodule : clamp_gain_offset_control
`default_nettype wire

// file: verif/clamp_gain_offset_control_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module clamp_gain_offset_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [clamp_gain_offset_pkg::CODE_W-1:0] adc_code_red,
  input wire logic [clamp_gain_offset_pkg::CODE_W-1:0] adc_code_green,
  input wire logic [clamp_gain_offset_pkg::CODE_W-1:0] corrected_code_red,
  input wire logic [clamp_gain_offset_pkg::CODE_W-1:0] corrected_code_green,
  input wire logic [clamp_gain_offset_pkg::GAIN_W-1:0] programmable_gain_amplifier_red,
  input wire logic clamp_active,
  input wire logic clamp_midscale_blue
);
  import clamp_gain_offset_pkg::*;
  // saturating age since reset
  logic [1:0] age_reg, age_next;
  always_comb begin
    age_next = (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      age_reg <= 2'h0;
    end else begin
      age_reg <= age_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_reset_quiet;
    $past(rst) |-> !clamp_active && !sda_oe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("output active after reset");
  property p_open_drain;
    sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
  property p_ack_scl_low;
    $changed(sda_oe) |-> !scl && !$past(scl);
  endproperty
  a_ack_scl_low: assert property (p_ack_scl_low) else $error("data changed with clock high");
  property p_ack_hold;
    $rose(sda_oe) |-> sda_oe [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("data low too short");
  property p_gain_write;
    age_reg == 2'h3 && $changed(programmable_gain_amplifier_red) |-> !scl;
  endproperty
  a_gain_write: assert property (p_gain_write)
    else $error("gain moved without a write");
  property p_mid_write;
    age_reg == 2'h3 && $changed(clamp_midscale_blue) |-> !scl && !$past(scl);
  endproperty
  a_mid_write: assert property (p_mid_write)
    else $error("target select moved without a write");
  property p_red_step;
    age_reg == 2'h3 && $stable(adc_code_red) && scl && $past(scl, 6)
      |=> (corrected_code_red + 10'h001 - $past(corrected_code_red)) <= 10'h002;
  endproperty
  a_red_step: assert property (p_red_step)
    else $error("restore step above one code");
  property p_green_hold;
    age_reg == 2'h3 && !clamp_active && !$past(clamp_active) && !$past(clamp_active, 2)
      && $stable(adc_code_green) && scl && $past(scl, 6) |=> $stable(corrected_code_green);
  endproperty
  a_green_hold: assert property (p_green_hold)
    else $error("correction moved outside clamp");
endmodule : clamp_gain_offset_monitor
bind clamp_gain_offset_control clamp_gain_offset_monitor mon_u (
  .clk(clk), .rst(rst), .scl(scl), .sda_out(sda_out), .sda_oe(sda_oe),
  .adc_code_red(adc_code_red), .adc_code_green(adc_code_green),
  .corrected_code_red(corrected_code_red), .corrected_code_green(corrected_code_green),
  .programmable_gain_amplifier_red(programmable_gain_amplifier_red),
  .clamp_active(clamp_active), .clamp_midscale_blue(clamp_midscale_blue)
);
`default_nettype wire

// file: verif/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h4c // arbitrary value
) (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge clk);
  endtask : hw
  task automatic start_c;
    hw(5);
    sda_drv = 1'b1;
    hw(10);
    scl = 1'b1;
    hw(10);
    sda_drv = 1'b0;
    hw(10);
    scl = 1'b0;
  endtask : start_c
  task automatic stop_c;
    hw(5);
    sda_drv = 1'b0;
    hw(10);
    scl = 1'b1;
    hw(10);
    sda_drv = 1'b1;
    hw(10);
  endtask : stop_c
  // eight bits msb first, then ack slot
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      hw(5);
      sda_drv = tx[i];
      hw(10);
      scl = 1'b1;
      hw(10);
      rx[i] = sda_line;
      scl = 1'b0;
    end
  endtask : xfer
  task automatic write_reg(input logic [7:0] a, input logic [7:0] v, output logic ok);
    logic [8:0] r0, r1, r2;
    start_c();
    xfer({DEV_ADDR, 1'b0, 1'b1}, r0);
    xfer({a, 1'b1}, r1);
    xfer({v, 1'b1}, r2);
    stop_c();
    ok = !(r0[0] | r1[0] | r2[0]);
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] v, output logic ok);
    logic [8:0] r0, r1, r2, r3;
    start_c();
    xfer({DEV_ADDR, 1'b0, 1'b1}, r0);
    xfer({a, 1'b1}, r1);
    start_c();
    xfer({DEV_ADDR, 1'b1, 1'b1}, r2);
    xfer(9'h1ff, r3);
    stop_c();
    v = r3[8:1];
    ok = !(r0[0] | r1[0] | r2[0]);
  endtask : read_reg
endmodule : i2c_host_model
`default_nettype wire

// file: verif/test_clamp_gain_offset_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_clamp_gain_offset_control;
  import clamp_gain_offset_pkg::*;
  logic clk, rst, scl, sda_drv, sda_out, sda_oe, hs_a, hs_b, hs_sel, cpin, clamp_on, ok;
  logic [CODE_W-1:0] adc_r, adc_g, adc_b, cor_r, cor_g, cor_b;
  logic [GAIN_W-1:0] pga_r, pga_g, pga_b;
  logic mid_r, mid_g, mid_b;
  logic [7:0] d;
  int miscompares, checks, lat0, lat1, len;
  wire logic sda_line = sda_drv & ~sda_oe;
  clamp_gain_offset_control dut_u (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .horizontal_sync_input_a(hs_a), .horizontal_sync_input_b(hs_b),
    .hsync_input_select(hs_sel), .clamp_pin(cpin), .adc_code_red(adc_r),
    .adc_code_green(adc_g), .adc_code_blue(adc_b), .corrected_code_red(cor_r),
    .corrected_code_green(cor_g), .corrected_code_blue(cor_b),
    .programmable_gain_amplifier_red(pga_r), .programmable_gain_amplifier_green(pga_g),
    .programmable_gain_amplifier_blue(pga_b), .clamp_active(clamp_on),
    .clamp_midscale_red(mid_r), .clamp_midscale_green(mid_g), .clamp_midscale_blue(mid_b)
  );
  i2c_host_model host_u (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
  task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_eq
  task automatic test_done;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host_u.write_reg(a, v, ok);
    check_eq(ok, 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host_u.read_reg(a, d, ok);
    check_eq(ok, 1'b1);
    check_eq(d, exp);
  endtask : rd
  // sync pulse on one input, then time the generated clamp
  task automatic run_sync(input logic use_b, output int lat, output int n);
    hs_sel = use_b;
    hs_a = ~use_b;
    hs_b = use_b;
    cyc(20);
    {hs_a, hs_b} = 2'b00;
    lat = 0;
    n = 0;
    while (clamp_on !== 1'b1 && lat < 400) begin
      cyc(1);
      lat++;
    end
    while (clamp_on === 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    if (lat >= 400 || n >= 400) begin
      miscompares++;
      test_done();
    end
  endtask : run_sync
  task automatic test_regs;
    rd(CLAMP_START_DELAY_ADDR, START_DELAY_RESET);
    rd(CLAMP_LENGTH_ADDR, LENGTH_RESET);
    rd(8'h11, 8'h00);
    check_eq(pga_r, GAIN_MAX);
    $display("test_regs done");
  endtask : test_regs
  task automatic test_gain;
    wr(GREEN_GAIN_UPPER_ADDR, 8'ha5);
    wr(GREEN_GAIN_LOWER_ADDR, 8'h80);
    wr(BLUE_GAIN_UPPER_ADDR, 8'hff);
    wr(BLUE_GAIN_LOWER_ADDR, 8'h80);
    check_eq(pga_g, GAIN_MAX - 9'h14b);
    check_eq(pga_b, 9'h000);
    check_eq(pga_r, GAIN_MAX);
    wr(RED_GAIN_LOWER_ADDR, 8'h80);
    check_eq(pga_r, 9'h1fe);
    rd(GREEN_GAIN_UPPER_ADDR, 8'ha5);
    $display("test_gain done");
  endtask : test_gain
  task automatic test_internal;
    wr(CLAMP_START_DELAY_ADDR, 8'h04);
    wr(CLAMP_LENGTH_ADDR, 8'h28);
    run_sync(1'b0, lat0, len);
    check_eq(16'(len), 16'h0028);
    wr(CLAMP_START_DELAY_ADDR, 8'h0e);
    run_sync(1'b1, lat1, len);
    check_eq(16'(lat1 - lat0), 16'h000a);
    check_eq(16'(len), 16'h0028);
    $display("test_internal done");
  endtask : test_internal
  task automatic test_external;
    adc_r = 10'h180;
    adc_g = 10'h010;
    adc_b = 10'h280;
    wr(CLAMP_CONFIGURATION_ADDR, 8'h1a);
    check_eq({mid_r, mid_g, mid_b}, 3'b101);
    cpin = 1'b1;
    cyc(10);
    check_eq(clamp_on, 1'b1);
    cyc(290);
    cpin = 1'b0;
    cyc(6);
    check_eq(clamp_on, 1'b0);
    check_eq(cor_r, MIDSCALE_CODE);
    check_eq(cor_g, GROUND_CODE);
    check_eq(cor_b, MIDSCALE_CODE);
    wr(CLAMP_CONFIGURATION_ADDR, 8'h5a);
    check_eq(clamp_on, 1'b1);
    cpin = 1'b1;
    cyc(6);
    check_eq(clamp_on, 1'b0);
    $display("test_external done");
  endtask : test_external
  task automatic test_offset;
    wr(RED_OFFSET_UPPER_ADDR, 8'h01);
    wr(RED_OFFSET_LOWER_ADDR, 8'h40);
    check_eq(cor_r, MIDSCALE_CODE + 10'h005);
    wr(RED_OFFSET_UPPER_ADDR, 8'h40);
    check_eq(cor_r, MIDSCALE_CODE - 10'h0ff);
    wr(OFFSET_MODE_CONTROL_ADDR, 8'h20);
    check_eq(cor_r, MIDSCALE_CODE);
    check_eq(cor_g, GROUND_CODE);
    $display("test_offset done");
  endtask : test_offset
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {hs_a, hs_b, hs_sel, cpin} = 4'h0;
    {adc_r, adc_g, adc_b} = 30'h0;
    cyc(4);
    rst = 1'b0;
    cyc(4);
    test_regs();
    test_gain();
    test_internal();
    test_external();
    test_offset();
    test_done();
  end
endmodule : test_clamp_gain_offset_control
`default_nettype wire
